// [hdl/tcrs_pkg.sv]
// Package of constants and types for the Type-C role strap and init block.
// Overview of operation
// - I2C interface is enabled whenever the address strap is pulled high or low.
// - Address strap low selects 7-bit I2C slave address 0x47.
// - Enable pin high puts the device into low-power shutdown.
// - Change alert line is asserted whenever the role or attached status changes.
// - Role strap low selects upstream facing port, sink.
// - Host role-select write is accepted only while unattached.
// - Unpowered device presents as sink with Rd on both CC lines.
// - After reset enter unattached and sample the role strap.
// - Unattached: watch CC for source attach, bus power for sink.
// - Enter active only after an attachment is detected.
// - Role strap open selects dual role, alternating source and sink.
// - Role strap high selects downstream facing port, source.
package tcrs_pkg;

  // Strap levels as sensed by the pad comparators.
  typedef enum logic [1:0] {
    TCRS_STRAP_LOW,
    TCRS_STRAP_HIGH,
    TCRS_STRAP_OPEN
  } tcrs_strap_type;

  typedef enum logic [1:0] {
    TCRS_ROLE_UFP,
    TCRS_ROLE_DFP,
    TCRS_ROLE_DRP
  } tcrs_role_type;

  typedef enum logic [1:0] {
    TCRS_ST_SHUTDOWN,
    TCRS_ST_UNATTACHED,
    TCRS_ST_ACTIVE
  } tcrs_state_type;

  typedef struct packed {
    logic          i2c_enable;
    logic [6:0]    i2c_address;
    tcrs_role_type role;
    logic          rd_on_cc;
    logic          rp_on_cc;
    logic          attached;
    logic          low_power;
  } tcrs_status_type;

  localparam logic [6:0] TCRS_ADDR_STRAP_LOW  = 7'h47;
  localparam logic [6:0] TCRS_ADDR_STRAP_HIGH = 7'h67;
  localparam int         TCRS_DRP_HALF_NS     = 50000;
  localparam int         TCRS_CLK_NS          = 5;
  localparam int         TCRS_DRP_HALF_CYC    = TCRS_DRP_HALF_NS / TCRS_CLK_NS;

endpackage

// [hdl/tcrs_drp_toggle.sv]
// Dual role toggle timer that alternates between source and sink presentation.
`timescale 1ns/1ps
module tcrs_drp_toggle #(
  parameter int HALF_CYC = tcrs_pkg::TCRS_DRP_HALF_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  output logic      as_source
);
  import tcrs_pkg::*;

  logic [31:0] count;
  wire         wrap = (count == 32'(HALF_CYC - 1));

  // The timer restarts at sink whenever it is stopped, so each search begins
  // with Rd present, which is the safe termination.
  always_ff @(posedge clk) begin
    if (!rst_n || !run) begin
      count     <= '0;
      as_source <= 1'b0;
    end else begin
      count     <= wrap ? '0 : count + 32'h1;
      as_source <= wrap ? ~as_source : as_source;
    end
  end
endmodule

// [hdl/tcrs_role_init.sv]
// Role strap decode, role override and power-up sequencing top module.
`timescale 1ns/1ps
module tcrs_role_init #(
  parameter int DRP_HALF_CYC = tcrs_pkg::TCRS_DRP_HALF_CYC
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // Strap and enable pins
  input  wire tcrs_pkg::tcrs_strap_type addr_strap,
  input  wire tcrs_pkg::tcrs_strap_type role_strap,
  input  wire logic                     enable_n,
  // Port partner sensing
  input  wire logic                     cc_sink_seen,
  input  wire logic                     cc_detached,
  input  wire logic                     bus_power_sense,
  // Role-select write from the I2C register file
  input  wire logic                     role_write,
  input  wire tcrs_pkg::tcrs_role_type  role_write_data,
  // Status and alert
  output tcrs_pkg::tcrs_status_type     status,
  output logic                          change_alert_line_o,
  output logic                          change_alert_line_oe,
  input  wire logic                     alert_clear
);
  import tcrs_pkg::*;

  tcrs_state_type  state;
  tcrs_state_type  next_state;
  tcrs_role_type   role;
  tcrs_role_type   next_role;
  tcrs_status_type next_status;
  logic            as_source;
  logic            attached_src;
  logic            first_cycle;

  function automatic tcrs_role_type strap_role(tcrs_strap_type s);
    unique case (s)
      TCRS_STRAP_LOW:  strap_role = TCRS_ROLE_UFP;
      TCRS_STRAP_HIGH: strap_role = TCRS_ROLE_DFP;
      default:         strap_role = TCRS_ROLE_DRP;
    endcase
  endfunction

  tcrs_drp_toggle #(.HALF_CYC(DRP_HALF_CYC)) u_toggle (
    .clk       (clk),
    .rst_n     (rst_n),
    .run       (state == TCRS_ST_UNATTACHED && role == TCRS_ROLE_DRP),
    .as_source (as_source)
  );

  // Presentation while searching: fixed roles, or the toggle phase for DRP.
  wire search_src  = (role == TCRS_ROLE_DFP) ||
                     (role == TCRS_ROLE_DRP && as_source);
  // The toggle stops once attached, so the side that made the attach is held;
  // otherwise a dual role port would drop its Rp as soon as it attached.
  wire present_src = (state == TCRS_ST_ACTIVE) ? attached_src : search_src;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      attached_src <= 1'b0;
    end else if (state == TCRS_ST_UNATTACHED) begin
      attached_src <= search_src;
    end
  end
  wire attach_seen = present_src ? cc_sink_seen : bus_power_sense;
  wire detach_seen = (present_src || role == TCRS_ROLE_DFP) ? cc_detached
                                                           : !bus_power_sense;
  wire take_write  = role_write && state == TCRS_ST_UNATTACHED;

  always_comb begin
    next_state = state;
    next_role  = role;
    unique case (state)
      TCRS_ST_SHUTDOWN: if (!enable_n) begin
        next_state = TCRS_ST_UNATTACHED;
        next_role  = strap_role(role_strap);
      end
      TCRS_ST_UNATTACHED: begin
        if (first_cycle) next_role = strap_role(role_strap);
        if (take_write) next_role = role_write_data;
        if (attach_seen) next_state = TCRS_ST_ACTIVE;
      end
      TCRS_ST_ACTIVE: if (detach_seen) next_state = TCRS_ST_UNATTACHED;
      default: next_state = TCRS_ST_UNATTACHED;
    endcase
    if (enable_n) next_state = TCRS_ST_SHUTDOWN;
  end

  always_comb begin
    next_status.i2c_enable  = (addr_strap != TCRS_STRAP_OPEN);
    next_status.i2c_address = (addr_strap == TCRS_STRAP_LOW) ?
                              TCRS_ADDR_STRAP_LOW : TCRS_ADDR_STRAP_HIGH;
    next_status.role        = next_role;
    next_status.rp_on_cc    = (next_state != TCRS_ST_SHUTDOWN) && present_src;
    next_status.rd_on_cc    = !next_status.rp_on_cc;
    next_status.attached    = (next_state == TCRS_ST_ACTIVE);
    next_status.low_power   = (next_state == TCRS_ST_SHUTDOWN);
  end

  wire status_changed = (next_status.role != status.role) ||
                        (next_status.attached != status.attached);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state <= TCRS_ST_UNATTACHED;
      role  <= TCRS_ROLE_UFP;
    end else begin
      state <= next_state;
      role  <= next_role;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) first_cycle <= 1'b1;
    else        first_cycle <= 1'b0;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status               <= '{rd_on_cc: 1'b1, role: TCRS_ROLE_UFP,
                                default: '0};
      change_alert_line_oe <= 1'b0;
    end else begin
      status               <= next_status;
      // Set wins over a simultaneous clear so no change is lost.
      change_alert_line_oe <= status_changed ||
                              (change_alert_line_oe && !alert_clear);
    end
  end

  // Open drain: the line only ever pulls low.
  always_ff @(posedge clk) change_alert_line_o <= 1'b0;

  a_shutdown_entry: assert property (@(posedge clk) disable iff (!rst_n)
    enable_n |=> state == TCRS_ST_SHUTDOWN && status.low_power ##0 1)
    else $error("enable high did not shut down");
  a_write_locked: assert property (@(posedge clk) disable iff (!rst_n)
    role_write && state == TCRS_ST_ACTIVE && !enable_n |=> $stable(role))
    else $error("role changed while attached");
  a_addr_low: assert property (@(posedge clk) disable iff (!rst_n)
    addr_strap == TCRS_STRAP_LOW |=> status.i2c_address == 7'h47)
    else $error("wrong address for low strap");
  a_i2c_enable: assert property (@(posedge clk) disable iff (!rst_n)
    addr_strap != TCRS_STRAP_OPEN |=> status.i2c_enable)
    else $error("i2c not enabled");
  a_alert_set: assert property (@(posedge clk) disable iff (!rst_n)
    $changed(status.attached) |-> change_alert_line_oe)
    else $error("alert missing on change");
  a_active_cause: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCRS_ST_UNATTACHED ##1 state == TCRS_ST_ACTIVE
    |-> $past(attach_seen))
    else $error("active without attach");
  a_wake_strap: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCRS_ST_SHUTDOWN && !enable_n
    |=> role == strap_role($past(role_strap)))
    else $error("strap not resampled");
  a_ufp_sense: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCRS_ST_UNATTACHED && role == TCRS_ROLE_UFP && !enable_n
    && !bus_power_sense |=> state == TCRS_ST_UNATTACHED)
    else $error("sink attached without bus power");
  a_rd_default: assert property (@(posedge clk) disable iff (!rst_n)
    status.low_power |-> status.rd_on_cc)
    else $error("Rd missing in shutdown");

  // The first cycle after reset takes the strap, not the reset role.
  a_reset_strap: assert property (@(posedge clk) disable iff (!rst_n)
    first_cycle && !enable_n && !role_write
    |=> role == strap_role($past(role_strap)))
    else $error("strap not sampled after reset");

  // A sink never shows Rp while it searches.
  a_ufp_sink: assert property (@(posedge clk) disable iff (!rst_n)
    role == TCRS_ROLE_UFP && state == TCRS_ST_UNATTACHED && !enable_n
    |=> !status.rp_on_cc)
    else $error("sink role shows Rp");

  // A source always shows Rp while it searches.
  a_dfp_source: assert property (@(posedge clk) disable iff (!rst_n)
    role == TCRS_ROLE_DFP && state == TCRS_ST_UNATTACHED && !enable_n
    |=> status.rp_on_cc)
    else $error("source role lacks Rp");

  // The toggle restarts at sink whenever the port is shut down.
  a_drp_restart: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCRS_ST_SHUTDOWN |=> !as_source)
    else $error("toggle not restarted at sink");

  // A write while unattached lands in the role register.
  a_write_taken: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCRS_ST_UNATTACHED && role_write && !enable_n && !first_cycle
    |=> role == $past(role_write_data))
    else $error("role write not taken");

  // Shutdown keeps the port quiet and detached.
  a_shutdown_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state == TCRS_ST_SHUTDOWN && enable_n
    |=> !status.rp_on_cc && !status.attached)
    else $error("port active in shutdown");

  // An alert stands until the host clears it.
  a_alert_hold: assert property (@(posedge clk) disable iff (!rst_n)
    change_alert_line_oe && !alert_clear |=> change_alert_line_oe)
    else $error("alert dropped without clear");

  // The alert line may only ever pull low.
  a_alert_od: assert property (@(posedge clk) disable iff (!rst_n)
    change_alert_line_oe |-> !change_alert_line_o)
    else $error("alert line driven high");
endmodule

// [verification/tcrs_partner.sv]
// Port partner model answering the controller's CC terminations.
`timescale 1ns/1ps
module tcrs_partner (
  // Bench control
  input  wire logic plug,
  // Controller terminations
  input  wire logic rp_seen,
  input  wire logic rd_seen,
  // Sensing toward the controller
  output logic      cc_sink_seen,
  output logic      cc_detached,
  output logic      bus_power_sense
);
  assign cc_sink_seen    = plug & rp_seen;
  assign cc_detached     = ~plug;
  assign bus_power_sense = plug & rd_seen;
endmodule

// [verification/tcrs_role_init_tb.sv]
// Self-checking bench for the role strap and init block.
`timescale 1ns/1ps
module tcrs_role_init_tb;
  import tcrs_pkg::*;
  logic            clk, rst_n, en_n, plug, wr, clr, sink, det, vb, ao, aoe;
  tcrs_strap_type  addr, role;
  tcrs_role_type   wdat;
  tcrs_status_type st;
  int              miscompares, check_count;
  tcrs_role_init #(.DRP_HALF_CYC(8)) dut_u (.clk(clk), .rst_n(rst_n),
    .addr_strap(addr), .role_strap(role), .enable_n(en_n),
    .cc_sink_seen(sink), .cc_detached(det), .bus_power_sense(vb),
    .role_write(wr), .role_write_data(wdat), .status(st),
    .change_alert_line_o(ao), .change_alert_line_oe(aoe),
    .alert_clear(clr));
  tcrs_partner partner_u (.plug(plug), .rp_seen(st.rp_on_cc),
    .rd_seen(st.rd_on_cc), .cc_sink_seen(sink), .cc_detached(det),
    .bus_power_sense(vb));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  task automatic after(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // A new strap level is only taken in on leaving shutdown or in the first cycle after reset.
  task automatic cycle_en(input tcrs_strap_type s);
    @(posedge clk);
    role <= s;
    en_n <= 1'b1;
    after(1);
    chk(st.low_power, 1'b1);
    en_n <= 1'b0;
    after(1);
    chk(st.low_power, 1'b0);
    chk(st.attached, 1'b0);
  endtask
  task automatic t_straps();
    tcrs_strap_type s[3] = '{TCRS_STRAP_LOW, TCRS_STRAP_HIGH,
                             TCRS_STRAP_OPEN};
    tcrs_role_type  r[3] = '{TCRS_ROLE_UFP, TCRS_ROLE_DFP, TCRS_ROLE_DRP};
    for (int i = 0; i < 3; i++) begin
      cycle_en(s[i]);
      chk(st.role, r[i]);
      addr <= s[i];
      after(1);
      chk(st.i2c_enable, i < 2);
    end
  endtask
  task automatic t_drp();
    int n;
    n = 0;
    repeat (40) begin
      after(1);
      n += st.rp_on_cc;
    end
    chk(n > 8 && n < 32, 1'b1);
  endtask
  task automatic t_write();
    cycle_en(TCRS_STRAP_LOW);
    wr   <= 1'b1;
    wdat <= TCRS_ROLE_DFP;
    after(1);
    chk(st.role, TCRS_ROLE_DFP);
    chk({ao, aoe}, 2'h1);
    wdat <= TCRS_ROLE_UFP;
    after(1);
    chk(st.role, TCRS_ROLE_UFP);
    wr  <= 1'b0;
    clr <= 1'b1;
    after(1);
    clr <= 1'b0;
    chk(aoe, 1'b0);
  endtask
  // Attach, then try a role write that must be refused.
  task automatic t_attach(input tcrs_strap_type s, input tcrs_role_type r);
    cycle_en(s);
    plug <= 1'b1;
    // A source needs one cycle to show Rp before the partner answers.
    for (int k = 0; k < 4 && !st.attached; k++) after(1);
    chk(st.attached, 1'b1);
    chk(aoe, 1'b1);
    wr   <= 1'b1;
    wdat <= TCRS_ROLE_DRP;
    after(1);
    wr   <= 1'b0;
    plug <= 1'b0;
    chk(st.role, r);
  endtask
  initial begin
    {rst_n, en_n, plug, wr, clr} = 5'h00;
    addr = TCRS_STRAP_LOW;
    role = TCRS_STRAP_LOW;
    wdat = TCRS_ROLE_UFP;
    miscompares = 0;
    check_count = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    after(1);
    chk(st.role, TCRS_ROLE_UFP);
    chk(st.rd_on_cc, 1'b1);
    chk(st.i2c_address, 7'h47);
    t_straps();
    t_drp();
    t_write();
    t_attach(TCRS_STRAP_LOW, TCRS_ROLE_UFP);
    t_attach(TCRS_STRAP_HIGH, TCRS_ROLE_DFP);
    summarize();
  end
endmodule
